// ### rtl/usb_endpoint_mode_handshake.sv
// endpoint mode, handshake and register interlock logic of the serial interface engine
//
// Added by the designer: the APB slave port and the address map.
module usb_endpoint_mode_handshake (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // packet decoder
    input wire usb_ep_pkg::token_t token,
    input wire usb_ep_pkg::packet_t packet,
    input wire logic host_ack,
    input wire logic buf_corrupt,
    // transmitter
    output usb_ep_pkg::resp_t resp,
    // endpoint interrupt requests
    output logic [2:0] ep_irq
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT_DATA = 2'h1,
        ST_WAIT_ACK = 2'h2
    } fsm_t;

    typedef struct packed {
        fsm_t fsm;
        logic [1:0] ep;
        usb_ep_pkg::pid_t pid;
        logic [2:0][3:0] mode;
        logic [2:0][3:0] cnt;
        logic [2:0] st_setup;
        logic [2:0] st_in;
        logic [2:0] st_out;
        logic [2:0] dval;
        logic [2:0] tog;
        logic [2:0] ien;
        logic lock;
        usb_ep_pkg::resp_t resp;
        logic [2:0] irq;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    localparam state_t RST_STATE = '0;

    state_t q;
    state_t d;

    logic apb_wr;
    logic apb_rd;
    logic [3:0] cur_mode;
    logic [1:0] idx;
    logic pkt_ok;
    usb_ep_pkg::action_t act;
    logic [2:0] irq_ev;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = psel && penable;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign resp = q.resp;
    assign ep_irq = q.irq;

    always_comb begin
        d = q;
        d.resp.valid = 1'b0;
        irq_ev = 3'h0;
        act = usb_ep_pkg::ACT_IGNORE;
        idx = (q.fsm == ST_IDLE) ? token.ep : q.ep;
        cur_mode = (idx == 2'h3) ? usb_ep_pkg::MODE_DISABLED : q.mode[idx];
        pkt_ok = (packet.count <= usb_ep_pkg::MAX_PKT_CNT) && packet.crc_ok;

        // apb read data captured in the setup phase
        if (psel && !penable) begin
            d.prdata = 32'h0;
            d.pslverr = 1'b0;
            unique case (paddr)
                usb_ep_pkg::REG_MODE0, usb_ep_pkg::REG_MODE1, usb_ep_pkg::REG_MODE2: begin
                    idx = paddr[3:2];
                    d.prdata[usb_ep_pkg::MODE_LSB +: 4] = q.mode[idx];
                    d.prdata[usb_ep_pkg::ST_OUT_BIT] = q.st_out[idx];
                    d.prdata[usb_ep_pkg::ST_IN_BIT] = q.st_in[idx];
                    d.prdata[usb_ep_pkg::ST_SETUP_BIT] = q.st_setup[idx];
                end
                usb_ep_pkg::REG_CNT0, usb_ep_pkg::REG_CNT1, usb_ep_pkg::REG_CNT2: begin
                    idx = 2'(paddr[4:2] - 3'h3);
                    d.prdata[usb_ep_pkg::CNT_LSB +: 4] = q.cnt[idx];
                    d.prdata[usb_ep_pkg::DVAL_BIT] = q.dval[idx];
                    d.prdata[usb_ep_pkg::TOG_BIT] = q.tog[idx];
                end
                usb_ep_pkg::REG_IEN: begin
                    d.prdata[2:0] = q.ien;
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
            idx = (q.fsm == ST_IDLE) ? token.ep : q.ep;
        end

        // apb writes take effect at the access edge
        if (apb_wr) begin
            unique case (paddr)
                usb_ep_pkg::REG_MODE0: begin
                    if (!q.lock) begin
                        d.mode[0] = pwdata[usb_ep_pkg::MODE_LSB +: 4];
                        d.st_out[0] = pwdata[usb_ep_pkg::ST_OUT_BIT];
                        d.st_in[0] = pwdata[usb_ep_pkg::ST_IN_BIT];
                        d.st_setup[0] = pwdata[usb_ep_pkg::ST_SETUP_BIT];
                    end
                end
                usb_ep_pkg::REG_MODE1, usb_ep_pkg::REG_MODE2: begin
                    d.mode[paddr[3:2]] = pwdata[usb_ep_pkg::MODE_LSB +: 4];
                    d.st_out[paddr[3:2]] = pwdata[usb_ep_pkg::ST_OUT_BIT];
                    d.st_in[paddr[3:2]] = pwdata[usb_ep_pkg::ST_IN_BIT];
                    d.st_setup[paddr[3:2]] = pwdata[usb_ep_pkg::ST_SETUP_BIT];
                end
                usb_ep_pkg::REG_CNT0: begin
                    if (!q.lock) begin
                        d.cnt[0] = pwdata[usb_ep_pkg::CNT_LSB +: 4];
                        d.dval[0] = pwdata[usb_ep_pkg::DVAL_BIT];
                        d.tog[0] = pwdata[usb_ep_pkg::TOG_BIT];
                    end
                end
                usb_ep_pkg::REG_CNT1, usb_ep_pkg::REG_CNT2: begin
                    d.cnt[2'(paddr[4:2] - 3'h3)] = pwdata[usb_ep_pkg::CNT_LSB +: 4];
                    d.dval[2'(paddr[4:2] - 3'h3)] = pwdata[usb_ep_pkg::DVAL_BIT];
                    d.tog[2'(paddr[4:2] - 3'h3)] = pwdata[usb_ep_pkg::TOG_BIT];
                end
                usb_ep_pkg::REG_IEN: begin
                    d.ien = pwdata[2:0];
                end
                default: begin
                end
            endcase
        end

        if (apb_rd && q.fsm == ST_IDLE &&
            (paddr == usb_ep_pkg::REG_MODE0 || paddr == usb_ep_pkg::REG_CNT0)) begin
            d.lock = 1'b0;
        end

        // transaction engine, after software so hardware sets win
        unique case (q.fsm)
            ST_IDLE: begin
                if (token.strobe && token.ep != 2'h3 &&
                    cur_mode != usb_ep_pkg::MODE_DISABLED) begin
                    d.ep = token.ep;
                    d.pid = token.pid;
                    unique case (token.pid)
                        usb_ep_pkg::PID_SETUP: begin
                            if (usb_ep_pkg::setup_ok(cur_mode)) begin
                                d.fsm = ST_WAIT_DATA;
                            end
                        end
                        usb_ep_pkg::PID_IN: begin
                            act = usb_ep_pkg::in_action(cur_mode);
                            if (act != usb_ep_pkg::ACT_IGNORE) begin
                                d.resp.valid = 1'b1;
                                d.resp.code = act;
                                d.resp.count = (act == usb_ep_pkg::ACT_TXCNT) ?
                                               q.cnt[token.ep] : 4'h0;
                            end
                            if (act == usb_ep_pkg::ACT_NAK || act == usb_ep_pkg::ACT_STALL) begin
                                d.st_in[token.ep] = 1'b1;
                                irq_ev[token.ep] = 1'b1;
                            end
                            if (act == usb_ep_pkg::ACT_TX0 || act == usb_ep_pkg::ACT_TXCNT) begin
                                d.fsm = ST_WAIT_ACK;
                            end
                        end
                        usb_ep_pkg::PID_OUT: begin
                            if (usb_ep_pkg::out_action(cur_mode) != usb_ep_pkg::ACT_IGNORE) begin
                                d.fsm = ST_WAIT_DATA;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_WAIT_DATA: begin
                if (packet.start && q.pid == usb_ep_pkg::PID_SETUP) begin
                    d.st_setup[q.ep] = 1'b1;
                end
                if (token.strobe) begin
                    d.fsm = ST_IDLE;
                end else if (packet.done) begin
                    d.fsm = ST_IDLE;
                    if (q.pid == usb_ep_pkg::PID_SETUP) begin
                        d.tog[q.ep] = packet.toggle;
                        d.cnt[q.ep] = packet.count;
                        d.dval[q.ep] = pkt_ok;
                        irq_ev[q.ep] = 1'b1;
                        if (pkt_ok) begin
                            d.resp.valid = 1'b1;
                            d.resp.code = usb_ep_pkg::ACT_ACK;
                            d.resp.count = 4'h0;
                            d.mode[q.ep] = usb_ep_pkg::MODE_NAK_INOUT;
                            if (q.ep == 2'h0) begin
                                d.lock = 1'b1;
                            end
                        end
                    end else begin
                        act = usb_ep_pkg::out_action(cur_mode);
                        unique case (act)
                            usb_ep_pkg::ACT_ACK, usb_ep_pkg::ACT_ALWAYS: begin
                                d.st_out[q.ep] = 1'b1;
                                d.tog[q.ep] = packet.toggle;
                                d.cnt[q.ep] = packet.count;
                                d.dval[q.ep] = pkt_ok;
                                irq_ev[q.ep] = 1'b1;
                                if (pkt_ok && act == usb_ep_pkg::ACT_ACK) begin
                                    d.resp.valid = 1'b1;
                                    d.resp.code = usb_ep_pkg::ACT_ACK;
                                    d.resp.count = 4'h0;
                                    d.mode[q.ep] = {cur_mode[3:1], 1'b0};
                                    if (q.ep == 2'h0) begin
                                        d.lock = 1'b1;
                                    end
                                end
                            end
                            usb_ep_pkg::ACT_NAK, usb_ep_pkg::ACT_STALL: begin
                                if (pkt_ok) begin
                                    d.resp.valid = 1'b1;
                                    d.resp.code = act;
                                    d.resp.count = 4'h0;
                                    d.st_out[q.ep] = 1'b1;
                                    irq_ev[q.ep] = 1'b1;
                                end
                            end
                            usb_ep_pkg::ACT_CHECK: begin
                                if (pkt_ok) begin
                                    d.resp.valid = 1'b1;
                                    d.resp.count = 4'h0;
                                    d.st_out[q.ep] = 1'b1;
                                    irq_ev[q.ep] = 1'b1;
                                    if (packet.count == usb_ep_pkg::ZLP_CNT && packet.toggle) begin
                                        d.resp.code = usb_ep_pkg::ACT_ACK;
                                        if (q.ep == 2'h0) begin
                                            d.lock = 1'b1;
                                        end
                                    end else begin
                                        d.resp.code = usb_ep_pkg::ACT_STALL;
                                    end
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            ST_WAIT_ACK: begin
                if (host_ack) begin
                    d.fsm = ST_IDLE;
                    d.st_in[q.ep] = 1'b1;
                    irq_ev[q.ep] = 1'b1;
                    if (cur_mode == usb_ep_pkg::MODE_ACK_IN ||
                        cur_mode == usb_ep_pkg::MODE_ACK_IN_STOUT) begin
                        d.mode[q.ep] = {cur_mode[3:1], 1'b0};
                    end
                    if (q.ep == 2'h0) begin
                        d.lock = 1'b1;
                    end
                end else if (token.strobe) begin
                    d.fsm = ST_IDLE;
                end
            end
            default: begin
                d.fsm = ST_IDLE;
            end
        endcase

        if (buf_corrupt && idx != 2'h3) begin
            irq_ev[idx] = 1'b1;
        end
        d.irq = irq_ev & q.ien;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= RST_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule : usb_endpoint_mode_handshake

// ### shared/usb_ep_pkg.sv
// constants, types and mode tables for the endpoint handshake engine
// Contract
// - disabled mode ignores every token silently
// - mode 0001 accepts setup, naks in/out
// - control modes 0010/0011/0100/0110 per table
// - isochronous out 0101, isochronous in 0111
// - 1001 acks out, then becomes 1000
// - 1011 acks out, then becomes 1010
// - 1101 sends count, then becomes 1100
// - 1111 sends count, then becomes 1110
// - all modes reset to disabled
// - accepted setup rewrites mode to 0001; the code does so only when the setup data is valid
// - accepted valid setup gets ack
// - status check needs zero length, toggle 1
// - invalid transactions get no response
// - irq on valid completion or corrupted buffer; setup and ack/iso out data also raise it when invalid
// - valid data is at most 10 bytes
// - non-control modes ignore setup tokens
// - out endpoints ignore in, and reverse
// - in/out status bits set at end
// - setup status set at data start
// - ack locks endpoint 0 mode/count writes
// - read after transaction clears the lock
// - one interrupt per endpoint, three endpoints
// - per endpoint enable bits, cleared at reset
package usb_ep_pkg;

    localparam int NUM_EP = 3;

    // register byte offsets
    localparam logic [7:0] REG_MODE0 = 8'h00;
    localparam logic [7:0] REG_MODE1 = 8'h04;
    localparam logic [7:0] REG_MODE2 = 8'h08;
    localparam logic [7:0] REG_CNT0 = 8'h0c;
    localparam logic [7:0] REG_CNT1 = 8'h10;
    localparam logic [7:0] REG_CNT2 = 8'h14;
    localparam logic [7:0] REG_IEN = 8'h18;

    // field positions
    localparam int MODE_LSB = 0;
    localparam int ST_OUT_BIT = 4;
    localparam int ST_IN_BIT = 5;
    localparam int ST_SETUP_BIT = 6;
    localparam int CNT_LSB = 0;
    localparam int DVAL_BIT = 6;
    localparam int TOG_BIT = 7;

    // packet limits: byte counts include the two crc bytes
    localparam logic [3:0] MAX_PKT_CNT = 4'ha;
    localparam logic [3:0] ZLP_CNT = 4'h2;

    localparam logic [3:0] MODE_DISABLED = 4'h0;
    localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
    localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
    localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
    localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
    localparam logic [3:0] MODE_ISO_OUT = 4'h5;
    localparam logic [3:0] MODE_STATUS_IN = 4'h6;
    localparam logic [3:0] MODE_ISO_IN = 4'h7;
    localparam logic [3:0] MODE_NAK_OUT = 4'h8;
    localparam logic [3:0] MODE_ACK_OUT = 4'h9;
    localparam logic [3:0] MODE_NAK_OUT_STIN = 4'ha;
    localparam logic [3:0] MODE_ACK_OUT_STIN = 4'hb;
    localparam logic [3:0] MODE_NAK_IN = 4'hc;
    localparam logic [3:0] MODE_ACK_IN = 4'hd;
    localparam logic [3:0] MODE_NAK_IN_STOUT = 4'he;
    localparam logic [3:0] MODE_ACK_IN_STOUT = 4'hf;

    typedef enum logic [1:0] {
        PID_SETUP = 2'h0,
        PID_IN = 2'h1,
        PID_OUT = 2'h2
    } pid_t;

    typedef enum logic [2:0] {
        ACT_IGNORE = 3'h0,
        ACT_ACK = 3'h1,
        ACT_NAK = 3'h2,
        ACT_STALL = 3'h3,
        ACT_TX0 = 3'h4,
        ACT_TXCNT = 3'h5,
        ACT_CHECK = 3'h6,
        ACT_ALWAYS = 3'h7
    } action_t;

    // token from the packet decoder
    typedef struct packed {
        logic strobe;
        pid_t pid;
        logic [1:0] ep;
    } token_t;

    // data packet from the packet decoder
    typedef struct packed {
        logic start;
        logic done;
        logic [3:0] count;
        logic crc_ok;
        logic toggle;
    } packet_t;

    // handshake or data request to the transmitter
    typedef struct packed {
        logic valid;
        action_t code;
        logic [3:0] count;
    } resp_t;

    function automatic logic setup_ok(input logic [3:0] m);
        unique case (m)
            MODE_NAK_INOUT, MODE_STATUS_OUT, MODE_STALL_INOUT, MODE_IGNORE_INOUT,
            MODE_STATUS_IN, MODE_NAK_OUT_STIN, MODE_ACK_OUT_STIN,
            MODE_NAK_IN_STOUT, MODE_ACK_IN_STOUT: setup_ok = 1'b1;
            default: setup_ok = 1'b0;
        endcase
    endfunction : setup_ok

    function automatic action_t in_action(input logic [3:0] m);
        unique case (m)
            MODE_NAK_INOUT, MODE_NAK_IN, MODE_NAK_IN_STOUT: in_action = ACT_NAK;
            MODE_STATUS_OUT, MODE_STALL_INOUT: in_action = ACT_STALL;
            MODE_STATUS_IN, MODE_NAK_OUT_STIN, MODE_ACK_OUT_STIN: in_action = ACT_TX0;
            MODE_ISO_IN, MODE_ACK_IN, MODE_ACK_IN_STOUT: in_action = ACT_TXCNT;
            default: in_action = ACT_IGNORE;
        endcase
    endfunction : in_action

    function automatic action_t out_action(input logic [3:0] m);
        unique case (m)
            MODE_NAK_INOUT, MODE_NAK_OUT, MODE_NAK_OUT_STIN: out_action = ACT_NAK;
            MODE_STALL_INOUT, MODE_STATUS_IN: out_action = ACT_STALL;
            MODE_STATUS_OUT, MODE_NAK_IN_STOUT, MODE_ACK_IN_STOUT: out_action = ACT_CHECK;
            MODE_ISO_OUT: out_action = ACT_ALWAYS;
            MODE_ACK_OUT, MODE_ACK_OUT_STIN: out_action = ACT_ACK;
            default: out_action = ACT_IGNORE;
        endcase
    endfunction : out_action

endpackage : usb_ep_pkg

// ### tb/usb_endpoint_mode_handshake_tb_top.sv
// self-checking bench for the endpoint handshake engine
module usb_endpoint_mode_handshake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, host_ack, buf_corrupt;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    usb_ep_pkg::token_t token;
    usb_ep_pkg::packet_t packet;
    usb_ep_pkg::resp_t resp;
    logic [2:0] ep_irq, irq, c;
    logic [3:0] m, cnt, x;
    int n_fail = 0, check_count = 0;
    // answer code per mode, one nibble each; setup table one ack bit each
    localparam logic [63:0] IN_T = 64'h5252_4400_5400_3320;
    localparam logic [63:0] OUT_T = 64'h1100_1212_0300_3120;
    localparam logic [15:0] SETUP_T = 16'hcc5e;
    usb_endpoint_mode_handshake i_usb_endpoint_mode_handshake (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .token(token), .packet(packet), .host_ack(host_ack),
        .buf_corrupt(buf_corrupt), .resp(resp), .ep_irq(ep_irq)
    );
    usb_host_model i_usb_host_model (
        .sys_clk(sys_clk), .token(token), .packet(packet), .host_ack(host_ack),
        .buf_corrupt(buf_corrupt)
    );
    initial forever #4 sys_clk = ~sys_clk;
    function automatic logic [2:0] code_of(input logic [63:0] t, input logic [3:0] md);
        return t[md*4 +: 3];
    endfunction : code_of
    function automatic logic [3:0] after(input logic [3:0] md, input logic in_dir);
        if (in_dir ? (md == 4'hd || md == 4'hf) : (md == 4'h9 || md == 4'hb)) return md - 4'h1;
        return md;
    endfunction : after
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        {q, err} = {prdata, pslverr};
        if (n >= 50) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic grab();
        {c, irq, x} = '0;
        repeat (3) begin
            @(posedge sys_clk);
            if (resp.valid === 1'b1) begin
                c = resp.code;
                x = resp.count;
            end
            irq = irq | ep_irq;
        end
    endtask : grab
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hb959));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            check("reset value", q, 32'h0);
        end
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped error", err, 1'b1);
        $display("test reset done");
        apb(1'b1, usb_ep_pkg::REG_IEN, 32'h7);
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            apb(1'b1, usb_ep_pkg::REG_MODE1, {28'h0, m});
            i_usb_host_model.tok(usb_ep_pkg::PID_SETUP, 2'h1);
            i_usb_host_model.dat(4'ha, 1'b1, 1'b0);
            grab();
            check("setup answer", c, {2'h0, SETUP_T[m]});
            apb(1'b0, usb_ep_pkg::REG_MODE1, 32'h0);
            check("setup mode", q[3:0], SETUP_T[m] ? 4'h1 : m);
            if (SETUP_T[m]) check("setup status", q[6], 1'b1);
            cnt = 4'($urandom_range(8, 0));
            apb(1'b1, usb_ep_pkg::REG_CNT1, {28'h0, cnt});
            apb(1'b1, usb_ep_pkg::REG_MODE1, {28'h0, m});
            i_usb_host_model.tok(usb_ep_pkg::PID_IN, 2'h1);
            grab();
            check("in answer", c, code_of(IN_T, m));
            if (c == 3'h5) check("in count", x, cnt);
            if (c[2]) i_usb_host_model.ack(4'($urandom_range(3, 0)));
            apb(1'b0, usb_ep_pkg::REG_MODE1, 32'h0);
            check("in mode", q[3:0], after(m, 1'b1));
            apb(1'b1, usb_ep_pkg::REG_MODE1, {28'h0, m});
            i_usb_host_model.tok(usb_ep_pkg::PID_OUT, 2'h1);
            i_usb_host_model.dat(4'h2, 1'b1, 1'b1);
            grab();
            check("out answer", c, code_of(OUT_T, m));
            check("out irq", irq, (code_of(OUT_T, m) || m == 4'h5) ? 3'h2 : 3'h0);
            apb(1'b0, usb_ep_pkg::REG_MODE1, 32'h0);
            check("out mode", q[3:0], after(m, 1'b0));
        end
        $display("test mode table done");
        apb(1'b1, usb_ep_pkg::REG_IEN, 32'h6);
        apb(1'b1, usb_ep_pkg::REG_MODE0, 32'h9);
        i_usb_host_model.tok(usb_ep_pkg::PID_OUT, 2'h0);
        i_usb_host_model.dat(4'h2, 1'b1, 1'b1);
        grab();
        check("ep0 ack", c, 3'h1);
        check("masked irq", irq, 3'h0);
        apb(1'b1, usb_ep_pkg::REG_MODE0, 32'h3);
        apb(1'b1, usb_ep_pkg::REG_CNT0, 32'h5);
        apb(1'b0, usb_ep_pkg::REG_MODE0, 32'h0);
        check("locked mode", q[3:0], 4'h8);
        apb(1'b0, usb_ep_pkg::REG_CNT0, 32'h0);
        check("locked count", q[3:0], 4'h2);
        apb(1'b1, usb_ep_pkg::REG_MODE0, 32'h3);
        apb(1'b0, usb_ep_pkg::REG_MODE0, 32'h0);
        check("unlocked mode", q[3:0], 4'h3);
        apb(1'b1, usb_ep_pkg::REG_MODE1, 32'h9);
        for (int k = 0; k < 2; k++) begin
            i_usb_host_model.tok(usb_ep_pkg::PID_OUT, 2'h1);
            i_usb_host_model.dat(k ? 4'h4 : 4'($urandom_range(15, 11)), k == 0, 1'b0);
            grab();
            check("bad data", c, 3'h0);
        end
        apb(1'b0, usb_ep_pkg::REG_MODE1, 32'h0);
        check("bad data mode", q[3:0], 4'h9);
        i_usb_host_model.tok(usb_ep_pkg::PID_IN, 2'h3);
        grab();
        check("unknown endpoint", c, 3'h0);
        i_usb_host_model.corrupt(2'h2);
        grab();
        check("corrupt irq", irq, 3'h4);
        $display("test interlock and errors done");
        finish_test();
    end
endmodule : usb_endpoint_mode_handshake_tb_top

// ### tb/usb_ep_props.sv
// port-level checks of the endpoint handshake engine
module usb_ep_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // link
    input wire usb_ep_pkg::token_t token,
    input wire usb_ep_pkg::packet_t packet,
    input wire logic host_ack,
    input wire logic buf_corrupt,
    input wire usb_ep_pkg::resp_t resp,
    input wire logic [2:0] ep_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_apb_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_bad_data;
        ce && packet.done && !token.strobe
            && (!packet.crc_ok || packet.count > usb_ep_pkg::MAX_PKT_CNT);
    endsequence
    AST_PREADY_ZERO_WAIT: assert property (s_apb_access |-> pready)
        else $error("access cycle without ready");
    AST_UNMAPPED_ERR: assert property (psel && penable && paddr > usb_ep_pkg::REG_IEN
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
    AST_RESP_CAUSE: assert property (resp.valid && $past(ce)
        |-> $past(token.strobe || packet.done || host_ack))
        else $error("answer without a cause");
    AST_TX_AFTER_IN: assert property (resp.valid && $past(ce)
        && resp.code inside {usb_ep_pkg::ACT_TX0, usb_ep_pkg::ACT_TXCNT}
        |-> $past(token.strobe && token.pid == usb_ep_pkg::PID_IN))
        else $error("data sent without in token");
    AST_ACK_VALID_DATA: assert property (resp.valid && resp.code == usb_ep_pkg::ACT_ACK
        && $past(ce) |-> $past(packet.done && packet.crc_ok
        && packet.count <= usb_ep_pkg::MAX_PKT_CNT))
        else $error("ack without valid data");
    AST_BAD_DATA_SILENT: assert property (s_bad_data |=> !resp.valid)
        else $error("answer to invalid data");
    AST_EP3_SILENT: assert property (ce && token.strobe && token.ep == 2'h3
        && !packet.done && !host_ack |=> !resp.valid)
        else $error("answer to unknown endpoint");
    AST_IRQ_CAUSE: assert property (|ep_irq && $past(ce)
        |-> $past(token.strobe || packet.done || host_ack || buf_corrupt))
        else $error("interrupt without a cause");
    AST_TX0_NO_COUNT: assert property (resp.valid && resp.code == usb_ep_pkg::ACT_TX0
        |-> resp.count == 4'h0)
        else $error("zero-length answer carries a count");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !rst_n |=> !resp.valid && ep_irq == 3'h0 && !pslverr)
        else $error("outputs active after reset");
endmodule : usb_ep_props

bind usb_endpoint_mode_handshake usb_ep_props i_usb_ep_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .token(token),
    .packet(packet), .host_ack(host_ack), .buf_corrupt(buf_corrupt), .resp(resp),
    .ep_irq(ep_irq)
);

// ### tb/usb_host_model.sv
// host model driving tokens, data packets and handshakes
module usb_host_model (
    // clock
    input wire logic sys_clk,
    // towards the engine
    output usb_ep_pkg::token_t token,
    output usb_ep_pkg::packet_t packet,
    output logic host_ack,
    output logic buf_corrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {token, packet, host_ack, buf_corrupt} = '0;
    end
    task automatic tok(input usb_ep_pkg::pid_t p, input logic [1:0] e);
        token <= '{strobe: 1'b1, pid: p, ep: e};
        @(posedge sys_clk);
        token <= '{strobe: 1'b0, pid: p, ep: ~e};
    endtask : tok
    task automatic dat(input logic [3:0] c, input logic ok, input logic tg);
        packet <= '{start: 1'b1, done: 1'b0, count: 4'h0, crc_ok: 1'b0, toggle: 1'b0};
        @(posedge sys_clk);
        packet <= '{start: 1'b0, done: 1'b1, count: c, crc_ok: ok, toggle: tg};
        @(posedge sys_clk);
        packet <= '{start: 1'b0, done: 1'b0, count: ~c, crc_ok: ~ok, toggle: ~tg};
    endtask : dat
    task automatic ack(input logic [3:0] gap);
        repeat (gap) @(posedge sys_clk);
        host_ack <= 1'b1;
        @(posedge sys_clk);
        host_ack <= 1'b0;
    endtask : ack
    task automatic corrupt(input logic [1:0] e);
        token <= '{strobe: 1'b0, pid: usb_ep_pkg::PID_IN, ep: e};
        buf_corrupt <= 1'b1;
        @(posedge sys_clk);
        buf_corrupt <= 1'b0;
    endtask : corrupt
endmodule : usb_host_model
